/* cfs_consts.vh */
`ifndef CFS_CONSTS_VH
`define CFS_CONSTS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CFS_OFS_CTRL 8'h00
`define CFS_OFS_CMD 8'h04
`define CFS_OFS_OPND 8'h08
`define CFS_OFS_PC 8'h0C
`define CFS_OFS_FLAGS 8'h10
`define CFS_OFS_SP 8'h14
`define CFS_OFS_SRC 8'h18
`define CFS_OFS_DST 8'h1C
`define CFS_OFS_CNT 8'h20
`define CFS_OFS_STAT 8'h24
`define CFS_OFS_REGOUT 8'h28
// ----------------------------------------
// Command codes (CMD bits 4:0), condition in CMD bits 11:8
// ----------------------------------------
`define CFS_OP_NOP 5'h00
`define CFS_OP_BCC 5'h01
`define CFS_OP_JMP 5'h02
`define CFS_OP_BSR 5'h03
`define CFS_OP_JSR 5'h04
`define CFS_OP_RTS 5'h05
`define CFS_OP_RTE 5'h06
`define CFS_OP_SLEEP 5'h07
`define CFS_OP_LDCI 5'h08
`define CFS_OP_LDCR 5'h09
`define CFS_OP_STC 5'h0A
`define CFS_OP_FLAGS_AND_IMM 5'h0B
`define CFS_OP_ORC 5'h0C
`define CFS_OP_FLAGS_XOR_IMM 5'h0D
`define CFS_OP_MOVE 5'h0E
`define CFS_OP_IRQ 5'h0F
// ----------------------------------------
// Flag bit positions in the condition code register
// ----------------------------------------
`define CFS_F_C 0
`define CFS_F_V 1
`define CFS_F_Z 2
`define CFS_F_N 3
`define CFS_F_I 7
// ----------------------------------------
// Control field positions and reset values
// ----------------------------------------
`define CFS_CTRL_SUB 0
`define CFS_CTRL_HALT_LSB 4
`define CFS_RST_PC 16'h0000
`define CFS_RST_FLAGS 8'h80
`define CFS_RST_SP 16'hFF80
// ----------------------------------------
// Bus cycle lengths in states
// ----------------------------------------
`define CFS_MEM_STATES 2'd2
`define CFS_IO2_STATES 2'd2
`define CFS_IO3_STATES 2'd3
`endif

/* cfs_core.v */
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "cfs_consts.vh"

// Summary of operation
// - Conditional branch jumps on its flag condition, else falls through.
// - Subroutine return pops program counter and resumes there.
// - Exception return pops flags and program counter, leaving the handler.
// - Sleep moves the core into the selected power-down mode.
// - Load flags writes immediate or register byte into condition codes.
// - Store flags copies condition codes into a general register.
// - Flag logic ANDs, ORs or XORs condition codes with immediate.
// - No operation only advances program counter by two.
// - Block move copies bytes while count nonzero, incrementing both pointers.
// - Next command starts only after the block move completes.
// - One state is one rising edge of the active clock.
// - Bus cycles last two or three states depending on target.
// - Memory accesses take two states over sixteen bits, byte or word.
// - Peripheral accesses are byte-only; a word becomes two byte accesses.
// - Four top states: reset, execution, halt, exception handling.
// - Execution runs on system clock or on subclock in subactive mode.
// - Halt offers sleep, standby, watch and sub-sleep modes.
// - Exception handling is transient, entered on reset, interrupt or wake from halt.
// - Interrupt pushes program counter and flags using the stack pointer.
module cfs_core #(
   parameter AW = 16,
   parameter DW = 16
) (
   // System
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // Internal memory / peripheral bus
   output reg mreq_o,
   output reg mwe_o,
   output reg mword_o,
   output reg [AW-1:0] madr_o,
   output reg [DW-1:0] mdat_o,
   input wire [DW-1:0] mdat_i,
   input wire mio_i,
   input wire mslow_i,
   // Clocking and state
   output reg sub_clk_sel_o,
   output reg [1:0] top_state_o,
   output reg [1:0] halt_mode_o,
   input wire wake_i
);

// ----------------------------------------
// States
// ----------------------------------------
localparam S_RESET = 2'd0;
localparam S_EXEC = 2'd1;
localparam S_HALT = 2'd2;
localparam S_EXCP = 2'd3;

localparam P_IDLE = 4'd0;
localparam P_WR = 4'd1;
localparam P_RD = 4'd2;
localparam P_WAIT = 4'd3;
localparam P_DONE = 4'd4;

reg [15:0] pc_r;
reg [7:0] ccr_r;
reg [15:0] sp_r;
reg [15:0] src_r;
reg [15:0] dst_r;
reg [7:0] cnt_r;
reg [7:0] regout_r;
reg [31:0] cmd_r;
reg [15:0] opnd_r;
reg [7:0] ctrl_r;
reg busy_r;
reg [1:0] top_r;
reg [3:0] ph_r;
reg [3:0] step_r;
reg [1:0] bcnt_r;
reg [1:0] blen_r;
reg [15:0] rdat_r;
reg bhalf_r;

wire [4:0] op = cmd_r[4:0];
wire [3:0] cc = cmd_r[11:8];
wire fc = ccr_r[`CFS_F_C];
wire fv = ccr_r[`CFS_F_V];
wire fz = ccr_r[`CFS_F_Z];
wire fn = ccr_r[`CFS_F_N];
// The target class is taken while the address is on the bus, never at launch.
wire [1:0] len_now = mio_i ? (mslow_i ? `CFS_IO3_STATES : `CFS_IO2_STATES) : `CFS_MEM_STATES;
reg take;

// ----------------------------------------
// Branch condition
// ----------------------------------------
always @* begin
   case (cc)
      4'h0: take = 1'b1;
      4'h1: take = 1'b0;
      4'h2: take = ~(fc | fz);
      4'h3: take = fc | fz;
      4'h4: take = ~fc;
      4'h5: take = fc;
      4'h6: take = ~fz;
      4'h7: take = fz;
      4'h8: take = ~fv;
      4'h9: take = fv;
      4'hA: take = ~fn;
      4'hB: take = fn;
      4'hC: take = ~(fn ^ fv);
      4'hD: take = fn ^ fv;
      4'hE: take = ~(fz | (fn ^ fv));
      default: take = fz | (fn ^ fv);
   endcase
end

// ----------------------------------------
// Wishbone slave, answers one cycle after the request
// ----------------------------------------
wire wb_req = cyc_i & stb_i & ~ack_o;
wire wb_wr = wb_req & we_i;
wire start = wb_wr & (adr_i == `CFS_OFS_CMD) & sel_i[0] & ~busy_r & (top_r != S_RESET);

always @(posedge clk_i) begin
   if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
   end else begin
      ack_o <= wb_req;
      dat_o <= 32'h0000_0000;
      if (wb_req & ~we_i) begin
         case (adr_i)
            `CFS_OFS_CTRL: dat_o <= {24'h00_0000, ctrl_r};
            `CFS_OFS_CMD: dat_o <= cmd_r;
            `CFS_OFS_OPND: dat_o <= {16'h0000, opnd_r};
            `CFS_OFS_PC: dat_o <= {16'h0000, pc_r};
            `CFS_OFS_FLAGS: dat_o <= {24'h00_0000, ccr_r};
            `CFS_OFS_SP: dat_o <= {16'h0000, sp_r};
            `CFS_OFS_SRC: dat_o <= {16'h0000, src_r};
            `CFS_OFS_DST: dat_o <= {16'h0000, dst_r};
            `CFS_OFS_CNT: dat_o <= {24'h00_0000, cnt_r};
            `CFS_OFS_STAT: dat_o <= {26'h0, halt_mode_o, top_r, 1'b0, busy_r};
            `CFS_OFS_REGOUT: dat_o <= {24'h00_0000, regout_r};
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end
end

// ----------------------------------------
// Execution engine
// ----------------------------------------
// A bus access lasts blen_r states; peripheral targets are byte only, so a
// word there is split into two byte accesses; a read fills the high byte first, a write sends the low byte in both.
always @(posedge clk_i) begin
   if (rst_i) begin
      pc_r <= `CFS_RST_PC;
      ccr_r <= `CFS_RST_FLAGS;
      sp_r <= `CFS_RST_SP;
      src_r <= 16'h0000;
      dst_r <= 16'h0000;
      cnt_r <= 8'h00;
      regout_r <= 8'h00;
      cmd_r <= 32'h0000_0000;
      opnd_r <= 16'h0000;
      ctrl_r <= 8'h00;
      busy_r <= 1'b0;
      top_r <= S_RESET;
      ph_r <= P_IDLE;
      step_r <= 4'h0;
      bcnt_r <= 2'd0;
      blen_r <= 2'd0;
      rdat_r <= 16'h0000;
      bhalf_r <= 1'b0;
      mreq_o <= 1'b0;
      mwe_o <= 1'b0;
      mword_o <= 1'b0;
      madr_o <= {AW{1'b0}};
      mdat_o <= {DW{1'b0}};
      sub_clk_sel_o <= 1'b0;
      halt_mode_o <= 2'd0;
   end else begin
      sub_clk_sel_o <= ctrl_r[`CFS_CTRL_SUB];
      if (top_r == S_RESET)
         top_r <= S_EXCP;
      else if (top_r == S_EXCP && !busy_r)
         top_r <= S_EXEC;
      if (top_r == S_HALT && wake_i)
         top_r <= S_EXCP;
      if (wb_wr && !busy_r) begin
         case (adr_i)
            `CFS_OFS_CTRL: ctrl_r <= dat_i[7:0];
            `CFS_OFS_OPND: opnd_r <= dat_i[15:0];
            `CFS_OFS_PC: pc_r <= dat_i[15:0];
            `CFS_OFS_FLAGS: ccr_r <= dat_i[7:0];
            `CFS_OFS_SP: sp_r <= dat_i[15:0];
            `CFS_OFS_SRC: src_r <= dat_i[15:0];
            `CFS_OFS_DST: dst_r <= dat_i[15:0];
            `CFS_OFS_CNT: cnt_r <= dat_i[7:0];
            default: ;
         endcase
      end
      if (start) begin
         cmd_r <= dat_i;
         busy_r <= 1'b1;
         step_r <= 4'h0;
         ph_r <= P_IDLE;
      end
      if (busy_r) begin
         if (ph_r == P_WAIT) begin
            bcnt_r <= bcnt_r + 2'd1;
            if (bcnt_r == 2'd0)
               blen_r <= len_now;
            if (bcnt_r + 2'd1 == blen_r) begin
               if (mio_i && mword_o && !bhalf_r) begin
                  rdat_r[15:8] <= mdat_i[7:0];
                  bhalf_r <= 1'b1;
                  madr_o <= madr_o + 16'h0001;
                  mdat_o <= {8'h00, mdat_o[7:0]};
                  bcnt_r <= 2'd0;
               end else begin
                  if (mio_i && mword_o)
                     rdat_r[7:0] <= mdat_i[7:0];
                  else
                     rdat_r <= mdat_i;
                  mreq_o <= 1'b0;
                  ph_r <= P_DONE;
               end
            end
         end else if (ph_r == P_DONE) begin
            ph_r <= P_IDLE;
            step_r <= step_r + 4'h1;
         end else begin
            case (op)
               `CFS_OP_NOP: begin
                  pc_r <= pc_r + 16'h0002;
                  busy_r <= 1'b0;
               end
               `CFS_OP_BCC: begin
                  pc_r <= take ? pc_r + 16'h0002 + opnd_r : pc_r + 16'h0002;
                  busy_r <= 1'b0;
               end
               `CFS_OP_JMP: begin
                  pc_r <= opnd_r;
                  busy_r <= 1'b0;
               end
               `CFS_OP_BSR, `CFS_OP_JSR: begin
                  if (step_r == 4'h0) begin
                     sp_r <= sp_r - 16'h0002;
                     bus_go(sp_r - 16'h0002, 1'b1, pc_r + 16'h0002);
                  end else begin
                     pc_r <= (op == `CFS_OP_BSR) ? pc_r + 16'h0002 + opnd_r : opnd_r;
                     busy_r <= 1'b0;
                  end
               end
               `CFS_OP_IRQ: begin
                  if (step_r == 4'h0) begin
                     top_r <= S_EXCP;
                     sp_r <= sp_r - 16'h0002;
                     bus_go(sp_r - 16'h0002, 1'b1, pc_r);
                  end else if (step_r == 4'h1) begin
                     sp_r <= sp_r - 16'h0002;
                     bus_go(sp_r - 16'h0002, 1'b1, {ccr_r, ccr_r});
                  end else begin
                     ccr_r[`CFS_F_I] <= 1'b1;
                     pc_r <= opnd_r;
                     busy_r <= 1'b0;
                  end
               end
               `CFS_OP_RTS: begin
                  if (step_r == 4'h0)
                     bus_go(sp_r, 1'b0, 16'h0000);
                  else begin
                     pc_r <= rdat_r;
                     sp_r <= sp_r + 16'h0002;
                     busy_r <= 1'b0;
                  end
               end
               `CFS_OP_RTE: begin
                  if (step_r == 4'h0)
                     bus_go(sp_r, 1'b0, 16'h0000);
                  else if (step_r == 4'h1) begin
                     ccr_r <= rdat_r[15:8];
                     bus_go(sp_r + 16'h0002, 1'b0, 16'h0000);
                  end else begin
                     pc_r <= rdat_r;
                     sp_r <= sp_r + 16'h0004;
                     busy_r <= 1'b0;
                  end
               end
               `CFS_OP_SLEEP: begin
                  halt_mode_o <= ctrl_r[`CFS_CTRL_HALT_LSB+1:`CFS_CTRL_HALT_LSB];
                  top_r <= S_HALT;
                  pc_r <= pc_r + 16'h0002;
                  busy_r <= 1'b0;
               end
               `CFS_OP_LDCI, `CFS_OP_LDCR: begin
                  ccr_r <= opnd_r[7:0];
                  pc_r <= pc_r + 16'h0002;
                  busy_r <= 1'b0;
               end
               `CFS_OP_STC: begin
                  regout_r <= ccr_r;
                  pc_r <= pc_r + 16'h0002;
                  busy_r <= 1'b0;
               end
               `CFS_OP_FLAGS_AND_IMM, `CFS_OP_ORC, `CFS_OP_FLAGS_XOR_IMM: begin
                  if (op == `CFS_OP_FLAGS_AND_IMM)
                     ccr_r <= ccr_r & opnd_r[7:0];
                  else if (op == `CFS_OP_ORC)
                     ccr_r <= ccr_r | opnd_r[7:0];
                  else
                     ccr_r <= ccr_r ^ opnd_r[7:0];
                  pc_r <= pc_r + 16'h0002;
                  busy_r <= 1'b0;
               end
               `CFS_OP_MOVE: begin
                  if (cnt_r == 8'h00) begin
                     pc_r <= pc_r + 16'h0004;
                     busy_r <= 1'b0;
                  end else if (step_r[0] == 1'b0) begin
                     bus_rd_byte(src_r);
                  end else begin
                     mreq_o <= 1'b1;
                     mwe_o <= 1'b1;
                     mword_o <= 1'b0;
                     madr_o <= dst_r;
                     mdat_o <= {8'h00, rdat_r[7:0]};
                     blen_r <= `CFS_MEM_STATES;
                     bcnt_r <= 2'd0;
                     bhalf_r <= 1'b0;
                     ph_r <= P_WAIT;
                     src_r <= src_r + 16'h0001;
                     dst_r <= dst_r + 16'h0001;
                     cnt_r <= cnt_r - 8'h01;
                  end
               end
               default: begin
                  pc_r <= pc_r + 16'h0002;
                  busy_r <= 1'b0;
               end
            endcase
         end
      end
   end
end

// ----------------------------------------
// Bus access launchers
// ----------------------------------------
// Launchers start at memory length; the first wait state sets the real length
// from the target class of the address then on the bus.
task bus_go;
   input [15:0] a;
   input w;
   input [15:0] d;
   begin
      mreq_o <= 1'b1;
      mwe_o <= w;
      mword_o <= 1'b1;
      madr_o <= a;
      mdat_o <= d;
      blen_r <= `CFS_MEM_STATES;
      bcnt_r <= 2'd0;
      bhalf_r <= 1'b0;
      ph_r <= P_WAIT;
   end
endtask

task bus_rd_byte;
   input [15:0] a;
   begin
      mreq_o <= 1'b1;
      mwe_o <= 1'b0;
      mword_o <= 1'b0;
      madr_o <= a;
      mdat_o <= 16'h0000;
      blen_r <= `CFS_MEM_STATES;
      bcnt_r <= 2'd0;
      bhalf_r <= 1'b0;
      ph_r <= P_WAIT;
   end
endtask

always @* begin
   top_state_o = top_r;
end

endmodule

/* cfs_core_monitor.sv */
`timescale 1ns/100ps
module cfs_core_monitor #(
   parameter AW = 16
) (
   // Watched ports
   input wire clk_i,
   input wire rst_i,
   input wire mreq_o,
   input wire mword_o,
   input wire [AW-1:0] madr_o,
   input wire mio_i,
   input wire mslow_i,
   input wire [1:0] top_state_o,
   input wire wake_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_rst_state;
      disable iff (1'b0) rst_i |=> top_state_o == 2'd0;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("state not reset");
   property p_rst_exit;
      $fell(rst_i) |-> ##[0:2] top_state_o == 2'd3 ##1 top_state_o == 2'd1;
   endproperty
   a_rst_exit: assert property (p_rst_exit) else $error("no exception after reset");
   property p_no_rst_state;
      !$past(rst_i) && !$past(rst_i, 2) |-> top_state_o != 2'd0;
   endproperty
   a_no_rst_state: assert property (p_no_rst_state) else $error("reset state seen");
   property p_exc_short;
      top_state_o == 2'd3 |-> ##[1:40] top_state_o != 2'd3;
   endproperty
   a_exc_short: assert property (p_exc_short) else $error("exception not transient");
   property p_mem_two;
      $rose(mreq_o) && !mio_i |=> mreq_o ##1 (!mreq_o || $changed(madr_o));
   endproperty
   a_mem_two: assert property (p_mem_two) else $error("memory access length");
   property p_io_len;
      $rose(mreq_o) && mio_i |=> mreq_o ##1 (((mslow_i && mreq_o) ##1
         (!mreq_o || $changed(madr_o))) or (!mslow_i && (!mreq_o || $changed(madr_o))));
   endproperty
   a_io_len: assert property (p_io_len) else $error("peripheral access length");
   property p_io_byte;
      mreq_o && mio_i |-> !mword_o;
   endproperty
   a_io_byte: assert property (p_io_byte) else $error("word access to peripheral");
   property p_halt_quiet;
      top_state_o == 2'd2 && $past(top_state_o) == 2'd2 |-> !mreq_o;
   endproperty
   a_halt_quiet: assert property (p_halt_quiet) else $error("bus busy in halt");
   property p_wake;
      top_state_o == 2'd2 && wake_i |-> ##[1:8] top_state_o == 2'd3;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not taken");
endmodule

bind cfs_core cfs_core_monitor #(.AW(AW)) u_mon (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .mreq_o(mreq_o),
   .mword_o(mword_o),
   .madr_o(madr_o),
   .mio_i(mio_i),
   .mslow_i(mslow_i),
   .top_state_o(top_state_o),
   .wake_i(wake_i)
);

/* cfs_mem_model.sv */
`timescale 1ns/100ps
module cfs_mem_model (
   // Internal bus
   input wire logic clk_i,
   input wire logic mreq_i,
   input wire logic mwe_i,
   input wire logic mword_i,
   input wire logic [15:0] madr_i,
   input wire logic [15:0] mdat_i,
   output logic [15:0] mdat_o,
   output logic mio_o,
   output logic mslow_o
);
   logic [7:0] mem [0:65535];
   logic [15:0] last_r = 16'h0000;
   logic [15:0] rd;
   // ----------------------------------------
   // Targets
   // ----------------------------------------
   // The top page is byte-wide peripheral space; one small slice needs a third state.
   assign mio_o = madr_i[15:8] == 8'hFF;
   assign mslow_o = mio_o && madr_i[7:0] >= 8'hA8 && madr_i[7:0] <= 8'hAD;
   assign rd = (mio_o || !mword_i) ? {2{mem[madr_i]}} :
      {mem[madr_i], mem[madr_i + 16'h0001]};
   // A released bus shows the inverse of its last value so stale data never looks valid.
   assign mdat_o = mreq_i ? rd : ~last_r;
   always @(posedge clk_i) begin
      last_r <= mdat_o;
      if (mreq_i && mwe_i) begin
         if (mword_i && !mio_o) begin
            mem[madr_i] <= mdat_i[15:8];
            mem[madr_i + 16'h0001] <= mdat_i[7:0];
         end else begin
            mem[madr_i] <= mdat_i[7:0];
         end
      end
   end
endmodule

/* cpu_control_flow_and_states_tb_top.sv */
`timescale 1ns/100ps
`include "cfs_consts.vh"
module cpu_control_flow_and_states_tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wake_i = 0;
   logic [7:0] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, q;
   wire [31:0] dat_o;
   wire ack_o, mreq_o, mwe_o, mword_o, mio_i, mslow_i, sub_clk_sel_o;
   wire [15:0] madr_o, mdat_o, mdat_i;
   wire [1:0] top_state_o, halt_mode_o;
   int err_total = 0, compares = 0;
   logic [7:0] fl [4] = '{8'h00, 8'h05, 8'h0A, 8'h08};
   always #2 clk_i = ~clk_i;
   cfs_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .mreq_o(mreq_o), .mwe_o(mwe_o), .mword_o(mword_o), .madr_o(madr_o), .mdat_o(mdat_o),
      .mdat_i(mdat_i), .mio_i(mio_i), .mslow_i(mslow_i), .sub_clk_sel_o(sub_clk_sel_o),
      .top_state_o(top_state_o), .halt_mode_o(halt_mode_o), .wake_i(wake_i));
   cfs_mem_model mm (.clk_i(clk_i), .mreq_i(mreq_o), .mwe_i(mwe_o), .mword_i(mword_o),
      .madr_i(madr_o), .mdat_i(mdat_o), .mdat_o(mdat_i), .mio_o(mio_i), .mslow_o(mslow_i));
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Holds the request until ack is sampled high, then drops it for one cycle.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask
   task poll();
      q = 32'h1;
      while (q[0] !== 1'b0) wb(1'b0, `CFS_OFS_STAT, 32'h0);
   endtask
   task cmd(input logic [4:0] op, input logic [31:0] o);
      wb(1'b1, `CFS_OFS_OPND, o);
      wb(1'b1, `CFS_OFS_CMD, {27'h0, op});
      poll();
   endtask
   task bcc(input logic [3:0] c);
      wb(1'b1, `CFS_OFS_OPND, 32'h10);
      wb(1'b1, `CFS_OFS_CMD, {20'h0, c, 3'h0, `CFS_OP_BCC});
      poll();
   endtask
   function logic take(input logic [3:0] c, input logic [7:0] f);
      logic [15:0] t;
      t = {f[2] | (f[3] ^ f[1]), !(f[2] | (f[3] ^ f[1])), f[3] ^ f[1], !(f[3] ^ f[1]),
         f[3], !f[3], f[1], !f[1], f[2], !f[2], f[0], !f[0], f[0] | f[2], !(f[0] | f[2]),
         1'b0, 1'b1};
      return t[c];
   endfunction
   task print_verdict();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #40000;
      err_total++;
      print_verdict();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      mm.mem[16'hF000] = 8'hA1;
      mm.mem[16'hF001] = 8'hB2;
      mm.mem[16'hF002] = 8'hC3;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rc(`CFS_OFS_FLAGS, 32'h80, "flags rst");
      rc(`CFS_OFS_SP, 32'hFF80, "sp rst");
      rc(8'h3C, 32'h0, "unmapped");
      for (int c = 0; c < 16; c++) begin
         for (int k = 0; k < 4; k++) begin
            cmd(`CFS_OP_LDCI, {24'h0, fl[k]});
            wb(1'b1, `CFS_OFS_PC, 32'h100);
            bcc(c[3:0]);
            rc(`CFS_OFS_PC, take(c[3:0], fl[k]) ? 32'h112 : 32'h102, "branch");
         end
      end
      cmd(`CFS_OP_LDCI, 32'h5A);
      rc(`CFS_OFS_FLAGS, 32'h5A, "ldc imm");
      cmd(`CFS_OP_FLAGS_AND_IMM, 32'h0F);
      rc(`CFS_OFS_FLAGS, 32'h0A, "and");
      cmd(`CFS_OP_ORC, 32'h81);
      rc(`CFS_OFS_FLAGS, 32'h8B, "or");
      cmd(`CFS_OP_FLAGS_XOR_IMM, 32'hFF);
      rc(`CFS_OFS_FLAGS, 32'h74, "xor");
      cmd(`CFS_OP_STC, 32'h0);
      rc(`CFS_OFS_REGOUT, 32'h74, "stc");
      cmd(`CFS_OP_LDCR, 32'h33);
      rc(`CFS_OFS_FLAGS, 32'h33, "ldc reg");
      wb(1'b1, `CFS_OFS_PC, 32'h200);
      cmd(`CFS_OP_NOP, 32'h0);
      rc(`CFS_OFS_PC, 32'h202, "nop pc");
      rc(`CFS_OFS_FLAGS, 32'h33, "nop flags");
      cmd(`CFS_OP_JMP, 32'h1234);
      rc(`CFS_OFS_PC, 32'h1234, "jump");
      wb(1'b1, `CFS_OFS_SP, 32'hFB00);
      wb(1'b1, `CFS_OFS_PC, 32'h300);
      cmd(`CFS_OP_BSR, 32'h20);
      rc(`CFS_OFS_PC, 32'h322, "call");
      rc(`CFS_OFS_SP, 32'hFAFE, "call sp");
      chk("push", {16'h0, mm.mem[16'hFAFE], mm.mem[16'hFAFF]}, 32'h302);
      cmd(`CFS_OP_RTS, 32'h0);
      rc(`CFS_OFS_PC, 32'h302, "return");
      rc(`CFS_OFS_SP, 32'hFB00, "ret sp");
      cmd(`CFS_OP_JSR, 32'h400);
      rc(`CFS_OFS_PC, 32'h400, "abs call");
      cmd(`CFS_OP_LDCI, 32'h05);
      wb(1'b1, `CFS_OFS_SP, 32'hFB00);
      wb(1'b1, `CFS_OFS_PC, 32'h500);
      cmd(`CFS_OP_IRQ, 32'h600);
      rc(`CFS_OFS_SP, 32'hFAFC, "irq sp");
      chk("irq pc", {16'h0, mm.mem[16'hFAFE], mm.mem[16'hFAFF]}, 32'h500);
      chk("irq flags", {24'h0, mm.mem[16'hFAFC]}, 32'h05);
      cmd(`CFS_OP_RTE, 32'h0);
      rc(`CFS_OFS_PC, 32'h500, "rte pc");
      rc(`CFS_OFS_FLAGS, 32'h05, "rte flags");
      wb(1'b1, `CFS_OFS_SRC, 32'hF000);
      wb(1'b1, `CFS_OFS_DST, 32'hFFA8);
      wb(1'b1, `CFS_OFS_CNT, 32'h3);
      wb(1'b1, `CFS_OFS_CMD, {27'h0, `CFS_OP_MOVE});
      wb(1'b1, `CFS_OFS_SRC, 32'h0);
      poll();
      rc(`CFS_OFS_SRC, 32'hF003, "busy src");
      rc(`CFS_OFS_DST, 32'hFFAB, "dst");
      rc(`CFS_OFS_CNT, 32'h0, "cnt");
      chk("moved", {8'h0, mm.mem[16'hFFA8], mm.mem[16'hFFA9], mm.mem[16'hFFAA]}, 32'hA1B2C3);
      wb(1'b1, `CFS_OFS_PC, 32'h700);
      cmd(`CFS_OP_MOVE, 32'h0);
      rc(`CFS_OFS_PC, 32'h704, "zero move");
      rc(`CFS_OFS_SRC, 32'hF003, "zero src");
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, `CFS_OFS_CTRL, m << 4);
         cmd(`CFS_OP_SLEEP, 32'h0);
         chk("halt", {30'h0, top_state_o}, 32'h2);
         chk("mode", {30'h0, halt_mode_o}, m);
         wake_i <= 1'b1;
         for (int n = 0; n < 20 && top_state_o !== 2'd1; n++) @(posedge clk_i);
         wake_i <= 1'b0;
         chk("wake", {30'h0, top_state_o}, 32'h1);
      end
      wb(1'b1, `CFS_OFS_CTRL, 32'h1);
      chk("subclk", {31'h0, sub_clk_sel_o}, 32'h1);
      wb(1'b1, `CFS_OFS_CTRL, 32'h0);
      chk("sysclk", {31'h0, sub_clk_sel_o}, 32'h0);
      print_verdict();
   end
endmodule
